// >>> bench/abx_pin_model.sv
/*
 * outside world on the i/o port pins of the execute block.
 * assumes a pin that nobody outside overpowers simply shows its output latch.
 */
`timescale 1ns/1ps
module abx_pin_model (
    input  wire logic [7:0] latch_in,
    input  wire logic [7:0] drive_en_in,
    input  wire logic [7:0] drive_val_in,
    output logic      [7:0] pins_out
);
    // an external driver wins over the latch, so read-back can differ from it
    assign pins_out = (drive_en_in & drive_val_in) | (~drive_en_in & latch_in);
endmodule

// >>> bench/add_and_bit_ops_execute_tb.sv
/*
 * self-checking bench for abx_exec: apb master, integer reference model, random ops.
 * assumes zero-wait apb and one instruction per write to the instruction register.
 */
`timescale 1ns/1ps
module add_and_bit_ops_execute_tb;
    import abx_pkg::*;
    logic        clock_in = 1'b0;
    logic        srst_in  = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [7:0]  drv_en   = 8'h00;
    logic [7:0]  drv_val  = 8'h00;
    logic [31:0] rng      = 32'h70da;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  pins;
    logic [7:0]  latch;
    logic        skip;
    logic [7:0]  acc;
    logic [31:0] rd;
    logic        e;
    int          fail_count = 0;
    int          total_checks = 0;
    int          mem [128];
    int          m_acc, m_c, m_dc, m_z, m_skip, m_mask, f, k;

    always #50 clock_in = ~clock_in;

    abx_exec u_abx_exec (.clock_in(clock_in), .srst_in(srst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .port_pins_in(pins), .port_latch_out(latch), .skip_out(skip), .acc_out(acc));
    abx_pin_model u_abx_pin_model (.latch_in(latch), .drive_en_in(drv_en), .drive_val_in(drv_val),
        .pins_out(pins));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        int n;
        @(posedge clock_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fail_count++;
            $display("MISMATCH %0t apb answer never came", $time);
            test_done;
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // masked port bits read the pins, the rest read the latch
    function automatic int rd_f(input int a);
        if (a != 6)
            return mem[a];
        return (((drv_en & drv_val) | (~drv_en & mem[6])) & m_mask) | (mem[6] & ~m_mask & 255);
    endfunction

    // ----------------------------------------------------------------
    // reference model and instruction issue
    // ----------------------------------------------------------------
    task automatic exec(input logic [13:0] i);
        logic [31:0] r2;
        logic        e2;
        int          a, r, b, fa;
        logic        add;
        apb(1'b1, OFF_INSN, {18'h0, i}, r2, e2);
        fa = i[6:0];
        b = i[9:7];
        add = (i[13:12] == CLS_LIT) ? (i[11:9] == LIT_ADD_HI) : (i[11:8] == BYTE_ADD);
        if (m_skip) begin
            m_skip = 0;
        end else if (i[13:12] == CLS_BIT) begin
            r = rd_f(fa);
            case (i[11:10])
                BOP_CLEAR:    mem[fa] = r & ~(1 << b);
                BOP_SET:      mem[fa] = r | (1 << b);
                BOP_SKIP_CLR: m_skip = ((r >> b) & 1) == 0;
                default:      m_skip = (r >> b) & 1;
            endcase
        end else begin
            a = (i[13:12] == CLS_LIT) ? i[7:0] : rd_f(fa);
            r = add ? m_acc + a : m_acc & a;
            if (add) begin
                m_c = r >> 8;
                m_dc = ((m_acc & 15) + (a & 15)) >> 4;
            end
            r = r & 255;
            m_z = (r == 0);
            if (i[13:12] != CLS_LIT && i[DEST_POS])
                mem[fa] = r;
            else
                m_acc = r;
        end
        @(negedge clock_in);
        check({24'h0, acc}, m_acc, "accumulator");
        check({31'h0, skip}, m_skip, "skip flag");
        check({24'h0, latch}, mem[6] & 255, "port latch");
        apb(1'b0, OFF_STATUS, 32'h0, r2, e2);
        check(r2 & 32'h3f, {26'h0, 1'b0, m_skip[0], 1'b0, m_z[0], m_dc[0], m_c[0]}, "status");
    endtask

    function automatic logic [13:0] bop(input logic [1:0] op, input int b, input int a);
        return {CLS_BIT, op, b[2:0], a[6:0]};
    endfunction

    task automatic set_file(input int a, input int v);
        for (int b = 0; b < 8; b++)
            exec(bop(BOP_CLEAR, b, a));
        exec({CLS_LIT, LIT_AND, 8'h00});
        exec({CLS_LIT, LIT_ADD_HI, 1'b0, v[7:0]});
        exec({CLS_BYTE, BYTE_ADD, 1'b1, a[6:0]});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        foreach (mem[j])
            mem[j] = 0;
        {m_acc, m_c, m_dc, m_z, m_skip, m_mask} = '0;
        repeat (8) @(posedge clock_in);
        srst_in <= 1'b0;
        apb(1'b0, OFF_STATUS, 32'h0, rd, e);
        check(rd, 32'h0, "status after reset");
        apb(1'b0, 8'h10, 32'h0, rd, e);
        check({e, rd[30:0]}, 32'h8000_0000, "unmapped read");
        apb(1'b1, OFF_ACC, 32'h55, rd, e);
        check({31'h0, e}, 32'h0, "accumulator write error");
        // the write edge has launched any change, so look after it settles
        @(negedge clock_in);
        check({24'h0, acc}, 32'h0, "read-only accumulator");
        apb(1'b1, OFF_INSN, 32'h0, rd, e);
        apb(1'b0, OFF_STATUS, 32'h0, rd, e);
        check(rd, 32'h20, "undecoded instruction flag");
        check({24'h0, acc}, 32'h0, "undecoded instruction is a nop");
        $display("test registers done");
        exec({CLS_LIT, LIT_ADD_HI, 1'b1, 8'h8f});
        exec({CLS_LIT, LIT_ADD_HI, 1'b0, 8'h71});
        exec({CLS_LIT, LIT_ADD_HI, 1'b0, 8'hff});
        exec({CLS_LIT, LIT_AND, 8'h0f});
        $display("test literal flags done");
        for (int a = 32; a < 40; a++)
            set_file(a, xs(a) & 255);
        set_file(127, 8'h80);
        exec(bop(BOP_SKIP_SET, 7, 127));
        exec({CLS_LIT, LIT_ADD_HI, 1'b0, 8'h01});
        exec(bop(BOP_SKIP_CLR, 6, 127));
        exec({CLS_BYTE, BYTE_AND, 1'b1, 7'h7f});
        $display("test skips done");
        drv_en <= 8'hff;
        drv_val <= 8'h3c;
        set_file(6, 8'hf0);
        apb(1'b1, OFF_PORT_MASK, 32'hff, rd, e);
        m_mask = 255;
        apb(1'b0, OFF_PORT_MASK, 32'h0, rd, e);
        check(rd, 32'hff, "port mask");
        exec({CLS_LIT, LIT_AND, 8'h00});
        exec({CLS_BYTE, BYTE_ADD, 1'b0, 7'h06});
        exec(bop(BOP_SET, 0, 6));
        $display("test port read-modify-write done");
        repeat (120) begin
            rng = xs(rng);
            f = 32 + rng[2:0];
            k = rng[23:16];
            case (rng[10:8])
                3'h0: exec({CLS_LIT, LIT_ADD_HI, rng[24], k[7:0]});
                3'h1: exec({CLS_BYTE, BYTE_ADD, rng[25], f[6:0]});
                3'h2: exec({CLS_LIT, LIT_AND, k[7:0]});
                3'h3: exec({CLS_BYTE, BYTE_AND, rng[25], f[6:0]});
                default: exec(bop(rng[9:8], rng[13:11], f));
            endcase
        end
        $display("test random mix done");
        srst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        srst_in <= 1'b0;
        @(negedge clock_in);
        check({15'h0, skip, latch, acc}, 32'h0, "state after mid-run reset");
        {m_acc, m_c, m_dc, m_z, m_skip, m_mask} = '0;
        mem[6] = 0;
        apb(1'b0, OFF_STATUS, 32'h0, rd, e);
        check(rd, 32'h0, "status after mid-run reset");
        apb(1'b0, OFF_PORT_MASK, 32'h0, rd, e);
        check(rd, 32'h0, "port mask after mid-run reset");
        exec({CLS_LIT, LIT_ADD_HI, 1'b0, 8'h12});
        $display("test mid-run reset done");
        test_done;
    end
endmodule

// >>> logic/abx_alu.sv
/*
 * combinational add / and unit with flag generation.
 * assumes operands are stable for the whole execute cycle.
 */
`timescale 1ns/1ps
module abx_alu
    import abx_pkg::*;
(
    input  wire logic [7:0] a_in,
    input  wire logic [7:0] b_in,
    input  wire logic       is_add_in,
    output logic      [7:0] res_out,
    output logic            carry_out,
    output logic            dcarry_out,
    output logic            zero_out
);
    logic [8:0] sum;
    logic [4:0] low;

    always_comb begin
        sum        = {1'b0, a_in} + {1'b0, b_in};
        low        = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
        res_out    = is_add_in ? sum[7:0] : (a_in & b_in);
        carry_out  = sum[8];
        dcarry_out = low[4];
        zero_out   = (res_out == 8'h00);
    end
endmodule

// >>> logic/abx_exec.sv
/*
 * execute stage for literal/file add, literal/file and, bit clear/set and
 * bit-test-and-skip. instructions come in over apb (write to the
 * instruction register), file registers live in a local 128-entry array.
 * assumes a single 10 MHz clock; apb is the only software path.
 */
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module abx_exec
    import abx_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [7:0]  port_pins_in,
    output logic      [7:0]  port_latch_out,
    output logic             skip_out,
    output logic      [7:0]  acc_out
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]  file_mem [0:127];
    logic [7:0]  acc_q;
    logic [2:0]  flags_q;
    logic        skip_q;
    logic [7:0]  port_mask_q;
    logic [7:0]  port_latch_q;
    logic        illegal_q;

    localparam logic [6:0] PORT_ADDR = 7'h06;

    logic        wr_en;
    logic        rd_en;
    logic        insn_wr;
    logic [13:0] insn;
    logic [6:0]  faddr;
    logic [2:0]  bidx;
    logic        dest;
    logic [7:0]  lit;
    logic [7:0]  fval;
    logic [7:0]  bmask;
    abx_op_type  op;
    logic [7:0]  alu_b;
    logic [7:0]  alu_res;
    logic        alu_c;
    logic        alu_dc;
    logic        alu_z;

    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction

    assign wr_en   = psel_in && penable_in && pwrite_in;
    assign rd_en   = psel_in && penable_in && !pwrite_in;
    assign insn_wr = wr_en && (paddr_in == OFF_INSN);
    assign insn    = pwdata_in[13:0];
    assign faddr   = insn[6:0];
    assign bidx    = insn[9:7];
    assign dest    = insn[DEST_POS];
    assign lit     = insn[7:0];
    assign bmask   = bit_mask(bidx);

    // ----------------------------------------------------------------
    // operand fetch: port pins replace the latch when masked as input
    // ----------------------------------------------------------------
    always_comb begin
        if (faddr == PORT_ADDR) begin
            fval = (port_pins_in & port_mask_q) | (port_latch_q & ~port_mask_q);
        end else begin
            fval = file_mem[faddr];
        end
    end

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    always_comb begin
        op = ABX_NONE_TYPE_UNUSED;
        case (insn[13:12])
            CLS_BYTE: begin
                if (insn[11:8] == BYTE_ADD) begin
                    op = ABX_ADDF;
                end else if (insn[11:8] == BYTE_AND) begin
                    op = ABX_ANDF;
                end
            end
            CLS_BIT: begin
                case (insn[11:10])
                    BOP_CLEAR: op = ABX_BCLR;
                    BOP_SET:   op = ABX_BSET;
                    default:   op = ABX_BTST;
                endcase
            end
            CLS_LIT: begin
                if (insn[11:9] == LIT_ADD_HI) begin
                    op = ABX_ADDL;
                end else if (insn[11:8] == LIT_AND) begin
                    op = ABX_ANDL;
                end
            end
            default: op = ABX_NONE_TYPE_UNUSED;
        endcase
    end

    assign alu_b = (op == ABX_ADDL || op == ABX_ANDL) ? lit : fval;

    abx_alu u_alu (
        .a_in       (acc_q),
        .b_in       (alu_b),
        .is_add_in  (op == ABX_ADDL || op == ABX_ADDF),
        .res_out    (alu_res),
        .carry_out  (alu_c),
        .dcarry_out (alu_dc),
        .zero_out   (alu_z)
    );

    // ----------------------------------------------------------------
    // execute: an instruction issued in the nop slot is discarded
    // ----------------------------------------------------------------
    logic exec;
    assign exec = insn_wr && !skip_q;

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            acc_q   <= ACC_RESET;
            flags_q <= FLAGS_RESET;
        end else if (exec) begin
            case (op)
                ABX_ADDL, ABX_ADDF: begin
                    if (op == ABX_ADDL || !dest) begin
                        acc_q <= alu_res;
                    end
                    flags_q <= {alu_z, alu_dc, alu_c};
                end
                ABX_ANDL, ABX_ANDF: begin
                    if (op == ABX_ANDL || !dest) begin
                        acc_q <= alu_res;
                    end
                    flags_q[FLAG_Z] <= alu_z;
                end
                default: begin
                    acc_q <= acc_q;
                end
            endcase
        end
    end

    // file writes, including bit clear/set (flags untouched)
    always_ff @(posedge clock_in) begin
        if (exec) begin
            case (op)
                ABX_ADDF, ABX_ANDF: begin
                    if (dest && faddr != PORT_ADDR) begin
                        file_mem[faddr] <= alu_res;
                    end
                end
                ABX_BCLR: begin
                    if (faddr != PORT_ADDR) begin
                        file_mem[faddr] <= fval & ~bmask;
                    end
                end
                ABX_BSET: begin
                    if (faddr != PORT_ADDR) begin
                        file_mem[faddr] <= fval | bmask;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // port output latch takes writes aimed at the port address
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            port_latch_q <= ACC_RESET;
        end else if (exec && faddr == PORT_ADDR) begin
            case (op)
                ABX_ADDF, ABX_ANDF: begin
                    if (dest) begin
                        port_latch_q <= alu_res;
                    end
                end
                ABX_BCLR: port_latch_q <= fval & ~bmask;
                ABX_BSET: port_latch_q <= fval | bmask;
                default:  port_latch_q <= port_latch_q;
            endcase
        end
    end

    // skip flag: the next issued instruction becomes a nop
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            skip_q <= 1'b0;
        end else if (exec && op == ABX_BTST) begin
            if (insn[10]) begin
                skip_q <= fval[bidx];
            end else begin
                skip_q <= !fval[bidx];
            end
        end else if (insn_wr) begin
            skip_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // apb: zero wait state, unmapped read returns zero with pslverr
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            port_mask_q <= PORT_MASK_RESET;
            illegal_q   <= 1'b0;
        end else begin
            if (wr_en && paddr_in == OFF_PORT_MASK) begin
                port_mask_q <= pwdata_in[7:0];
            end
            if (exec && op == ABX_NONE_TYPE_UNUSED) begin
                illegal_q <= 1'b1;
            end else if (exec) begin
                illegal_q <= 1'b0;
            end
        end
    end

    logic mapped;
    assign mapped = (paddr_in == OFF_INSN) || (paddr_in == OFF_ACC) ||
                    (paddr_in == OFF_STATUS) || (paddr_in == OFF_PORT_MASK);

    always_comb begin
        prdata_out = 32'h0000_0000;
        if (rd_en) begin
            case (paddr_in)
                OFF_ACC:       prdata_out = {24'h00_0000, acc_q};
                OFF_STATUS:    prdata_out = {26'h000_0000, illegal_q, skip_q, 1'b0, flags_q};
                OFF_PORT_MASK: prdata_out = {24'h00_0000, port_mask_q};
                default:       prdata_out = 32'h0000_0000;
            endcase
        end
    end

    assign pready_out     = 1'b1;
    assign pslverr_out    = psel_in && penable_in && !mapped;
    assign port_latch_out = port_latch_q;
    assign skip_out       = skip_q;
    assign acc_out        = acc_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_ADDL_ACC: assert property (@(posedge clock_in) disable iff (srst_in)
        exec && op == ABX_ADDL |=> acc_q == $past(acc_q) + $past(lit)) else $error("add literal wrong");
    AST_ADDF_DEST: assert property (@(posedge clock_in) disable iff (srst_in)
        exec && op == ABX_ADDF && dest |=> acc_q == $past(acc_q)) else $error("add file touched acc");
    AST_ANDF_FLAGS: assert property (@(posedge clock_in) disable iff (srst_in)
        exec && op == ABX_ANDF |=> flags_q[1:0] == $past(flags_q[1:0])) else $error("and changed carry");
    AST_ANDL_ACC: assert property (@(posedge clock_in) disable iff (srst_in)
        exec && op == ABX_ANDL |=> acc_q == ($past(acc_q) & $past(lit))) else $error("and literal wrong");
    AST_BIT_FLAGS: assert property (@(posedge clock_in) disable iff (srst_in)
        exec && (op == ABX_BCLR || op == ABX_BSET) |=> $stable(flags_q)) else $error("bit op moved flags");
    AST_BSET_ACC: assert property (@(posedge clock_in) disable iff (srst_in)
        exec && op == ABX_BSET |=> $stable(acc_q)) else $error("bit set moved acc");
    AST_SKIP_SET: assert property (@(posedge clock_in) disable iff (srst_in)
        exec && op == ABX_BTST && insn[10] |=> skip_q == $past(fval[bidx])) else $error("skip set wrong");
    AST_SKIP_CLR: assert property (@(posedge clock_in) disable iff (srst_in)
        exec && op == ABX_BTST && !insn[10] |=> skip_q == !$past(fval[bidx])) else $error("skip clr wrong");
    AST_NOP_SLOT: assert property (@(posedge clock_in) disable iff (srst_in)
        skip_q && insn_wr |=> $stable(acc_q) && $stable(flags_q) && !skip_q) else $error("nop slot ran");
    AST_ZERO: assert property (@(posedge clock_in) disable iff (srst_in)
        exec && (op == ABX_ADDL || op == ABX_ANDL) |=> flags_q[FLAG_Z] == (acc_q == 8'h00)) else $error("zero flag");

    COV_SKIP:  cover property (@(posedge clock_in) exec && op == ABX_BTST ##1 skip_q);
    COV_CARRY: cover property (@(posedge clock_in) exec && op == ABX_ADDL && alu_c);
    COV_PORT:  cover property (@(posedge clock_in) exec && op == ABX_BSET && faddr == PORT_ADDR);
endmodule

// >>> logic/abx_pkg.sv
/*
 * constants and types shared by the add / and / bit-op execute block:
 * opcode fields, flag positions, register offsets, reset values.
 * assumes a 14-bit instruction word and an 8-bit data path.
 */
//
// Contract
// - literal add into accumulator, update C DC Z
// - file add, destination bit picks target
// - file AND, destination select, zero only
// - literal AND into accumulator, zero only
// - clear indexed file bit, flags unchanged
// - set indexed file bit, flags unchanged
// - skip next when tested bit set
// - skip next when tested bit clear
// - bit ops encoded 01, op, index, address
// - taken skip costs two cycles, second nop
// - port read-modify-write uses pin levels
package abx_pkg;

    // ----------------------------------------------------------------
    // instruction fields
    // ----------------------------------------------------------------
    localparam int          INSN_W        = 14;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 7;
    localparam logic [1:0]  CLS_BIT       = 2'h1;
    localparam logic [1:0]  CLS_BYTE      = 2'h0;
    localparam logic [1:0]  CLS_LIT       = 2'h3;
    localparam logic [3:0]  BYTE_ADD      = 4'h7;
    localparam logic [3:0]  BYTE_AND      = 4'h5;
    localparam logic [2:0]  LIT_ADD_HI    = 3'h7;   // 111x
    localparam logic [3:0]  LIT_AND       = 4'h9;
    localparam logic [1:0]  BOP_CLEAR     = 2'h0;
    localparam logic [1:0]  BOP_SET       = 2'h1;
    localparam logic [1:0]  BOP_SKIP_CLR  = 2'h2;
    localparam logic [1:0]  BOP_SKIP_SET  = 2'h3;
    localparam int          DEST_POS      = 7;

    // ----------------------------------------------------------------
    // status flag positions and reset values
    // ----------------------------------------------------------------
    localparam int          FLAG_C        = 0;
    localparam int          FLAG_DC       = 1;
    localparam int          FLAG_Z        = 2;
    localparam logic [7:0]  ACC_RESET     = 8'h00;
    localparam logic [2:0]  FLAGS_RESET   = 3'h0;

    // ----------------------------------------------------------------
    // apb register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFF_INSN      = 8'h00;
    localparam logic [7:0]  OFF_ACC       = 8'h04;
    localparam logic [7:0]  OFF_STATUS    = 8'h08;
    localparam logic [7:0]  OFF_PORT_MASK = 8'h0c;
    localparam logic [7:0]  PORT_MASK_RESET = 8'h00;

    typedef enum logic [2:0] {
        ABX_NONE_TYPE_UNUSED,
        ABX_ADDL, ABX_ADDF, ABX_ANDL, ABX_ANDF, ABX_BCLR, ABX_BSET, ABX_BTST
    } abx_op_type;

endpackage
